/* File: hdl/cfgl_consts.svh */
/*
 Offsets, field positions, reset values and sequencer counts of the
 configuration loader. Assumes inclusion by bare name from hdl/.
*/
`ifndef CFGL_CONSTS_SVH
`define CFGL_CONSTS_SVH

`define CFGL_OFF_CTRL       32'h0000_0000
`define CFGL_OFF_STATUS     32'h0000_0004
`define CFGL_OFF_WORDS      32'h0000_0008
`define CFGL_OFF_ADDR       32'h0000_000c

`define CFGL_CTRL_REMOTE    0
`define CFGL_CTRL_BRIDGE    1
`define CFGL_CTRL_RESTART   2

`define CFGL_ST_FAST        4
`define CFGL_ST_STD         5
`define CFGL_ST_BUSY        6
`define CFGL_ST_DONE        7
`define CFGL_ST_INRST       8
`define CFGL_ST_YIELD       9

`define CFGL_WORDS_RST      24'h00_0100
`define CFGL_ADDR_CYC       3'h2
`define CFGL_DATA_CYC       3'h6
`define CFGL_RESP_OKAY      2'h0
`define CFGL_RESP_DECERR    2'h3

`define CFGL_SEL_FAST_33    4'h5
`define CFGL_SEL_FAST_18    4'h6
`define CFGL_SEL_STD_33     4'h7
`define CFGL_SEL_STD_18     4'h8
`define CFGL_SEL_STD_30     4'hb

`endif

/* File: hdl/cfgl_pin_sync.sv */
/*
 Three-stage pin synchroniser with a two-stage agreement filter.
 Assumes the input is asynchronous to aclk.
*/
`timescale 1ns/1ps

module cfgl_pin_sync #(
    parameter int W = 1
) (
    // Clock and reset
    input  wire logic         aclk,
    input  wire logic         aresetn,
    // Pin side and result
    input  wire logic [W-1:0] pin_in,
    input  wire logic [W-1:0] rst_val,
    output logic      [W-1:0] pin_out
);
    logic [W-1:0] s1_r;
    logic [W-1:0] s2_r;
    logic [W-1:0] s3_r;

    // First stage feeds only the second
    always_ff @(posedge aclk) begin
        s1_r <= pin_in;
        s2_r <= s1_r;
        s3_r <= s2_r;
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            pin_out <= rst_val;
        end else if (s2_r == s3_r) begin
            pin_out <= s3_r;
        end
    end
endmodule : cfgl_pin_sync

/* File: hdl/cfgl_pkg.sv */
/*
 Types and the scheme decoder of the configuration loader.
 Assumes cfgl_consts.svh is on the include path.
*/
`include "cfgl_consts.svh"

package cfgl_pkg;
    typedef enum logic [1:0] {ST_IDLE, ST_ADDR, ST_DATA, ST_DONE}
        cfgl_state_t;

    // Bit 1: fast delay, bit 0: standard delay
    function automatic logic [1:0] cfgl_decode(input logic [3:0] sel);
        cfgl_decode = 2'h0;
        if (sel == `CFGL_SEL_FAST_33 || sel == `CFGL_SEL_FAST_18) begin
            cfgl_decode = 2'h2;
        end
        if (sel == `CFGL_SEL_STD_33 || sel == `CFGL_SEL_STD_18 ||
            sel == `CFGL_SEL_STD_30) begin
            cfgl_decode = 2'h1;
        end
    endfunction : cfgl_decode
endpackage : cfgl_pkg

/* File: hdl/cfgl_top.sv */
/*
 Configuration loader: scheme decode, parallel flash sequencer,
 serial flash bridge and AXI4-Lite registers. Assumes pins arrive
 asynchronously and pad logic resolves the enables.
*/
`timescale 1ns/1ps
`include "cfgl_consts.svh"

// Summary of operation
// - Reload request low holds the loader in reset during flash programming.
// - A bridge forwards JTAG bytes as serial flash writes when enabled.
// - Parallel mode fetches 16-bit words and hands them to config memory.
// - The loader masters the flash, making all control and addressing.
// - Codes 0101 and 0110 select parallel loading with the fast delay.
// - Codes 0111, 1000 and 1011 select parallel loading, standard delay.
// - Without the top select pin parallel loading is never offered.
// - Every parallel scheme allows remote upgrade, with an optional mode.
// - A 24-bit word address is driven; flash data is gated by enable.
// - The loader stays in reset while reload or status line is low.
module cfgl_top
    import cfgl_pkg::*;
#(
    parameter bit HAS_SEL_MSB = 1'b1
) (
    // Clock and reset
    input  wire logic        aclk,
    input  wire logic        aresetn,
    // AXI4-Lite slave
    input  wire logic [31:0] s_axi_awaddr,
    input  wire logic        s_axi_awvalid,
    output logic             s_axi_awready,
    input  wire logic [31:0] s_axi_wdata,
    input  wire logic [3:0]  s_axi_wstrb,
    input  wire logic        s_axi_wvalid,
    output logic             s_axi_wready,
    output logic [1:0]       s_axi_bresp,
    output logic             s_axi_bvalid,
    input  wire logic        s_axi_bready,
    input  wire logic [31:0] s_axi_araddr,
    input  wire logic        s_axi_arvalid,
    output logic             s_axi_arready,
    output logic [31:0]      s_axi_rdata,
    output logic [1:0]       s_axi_rresp,
    output logic             s_axi_rvalid,
    input  wire logic        s_axi_rready,
    // Configuration pins
    input  wire logic [3:0]  scheme_select_pins,
    input  wire logic        reload_request_low,
    input  wire logic        chain_enable_low,
    input  wire logic        open_drain_status_low_i,
    output logic             open_drain_status_low_o,
    output logic             open_drain_status_low_oe,
    output logic             remote_update_mode,
    // Parallel flash
    output logic             loader_clock_out,
    output logic [23:0]      flash_word_address_bus,
    input  wire logic [15:0] flash_data_i,
    output logic [15:0]      flash_data_o,
    output logic             flash_data_oe,
    output logic             flash_reset_low,
    output logic             flash_ce_low,
    output logic             flash_oe_low,
    output logic             flash_avd_low,
    output logic             flash_we_low,
    // Configuration memory
    output logic [15:0]      cfg_word,
    output logic             cfg_word_valid,
    // JTAG bridge bytes and serial flash
    input  wire logic [7:0]  jtag_byte,
    input  wire logic        jtag_byte_valid,
    output logic             jtag_byte_ready,
    output logic             as_clk_o,
    output logic             as_cs_low_o,
    output logic             as_data_o,
    output logic             as_oe
);
    logic [3:0]  sel_s;
    logic        rr_s;
    logic        chain_s;
    logic        ods_s;
    logic [15:0] data_s;
    logic        in_rst;
    logic        in_rst_d_r;
    logic [1:0]  ap;
    logic        ap_fast_r;
    logic        ap_std_r;
    cfgl_state_t st_r;
    logic [2:0]  ph_r;
    logic [23:0] words_r;
    logic        pend_r;
    logic        remote_en_r;
    logic        bridge_en_r;
    logic        restart;
    logic        aw_hold_r;
    logic        w_hold_r;
    logic [31:0] awaddr_r;
    logic [31:0] wdata_r;
    logic [3:0]  wstrb_r;
    logic [3:0]  bit_cnt_r;
    logic [7:0]  sh_r;
    logic        bridge_act;

    cfgl_pin_sync #(.W(4)) u_sel (.aclk(aclk), .aresetn(aresetn),
        .pin_in(scheme_select_pins), .rst_val(4'h0), .pin_out(sel_s));
    cfgl_pin_sync #(.W(3)) u_ctl (.aclk(aclk), .aresetn(aresetn),
        .pin_in({reload_request_low, chain_enable_low,
                 open_drain_status_low_i}),
        .rst_val(3'h0), .pin_out({rr_s, chain_s, ods_s}));
    cfgl_pin_sync #(.W(16)) u_dat (.aclk(aclk), .aresetn(aresetn),
        .pin_in(flash_data_i), .rst_val(16'h0000), .pin_out(data_s));

    assign in_rst = !rr_s || !ods_s;
    // Missing top pin zeroes the decode and kills every parallel code
    assign ap = HAS_SEL_MSB ? cfgl_decode(sel_s) : 2'h0;
    assign bridge_act = bridge_en_r && !chain_s && (st_r != ST_ADDR) &&
                        (st_r != ST_DATA);
    assign restart = aw_hold_r && w_hold_r && !s_axi_bvalid &&
                     awaddr_r == `CFGL_OFF_CTRL && wstrb_r[0] &&
                     wdata_r[`CFGL_CTRL_RESTART];

    // Scheme flags, status pull-down and remote mode
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            ap_fast_r <= 1'b0;
            ap_std_r <= 1'b0;
            in_rst_d_r <= 1'b1;
            open_drain_status_low_o <= 1'b0;
            open_drain_status_low_oe <= 1'b1;
            remote_update_mode <= 1'b0;
        end else begin
            ap_fast_r <= ap[1];
            ap_std_r <= ap[0];
            in_rst_d_r <= in_rst;
            open_drain_status_low_o <= 1'b0;
            open_drain_status_low_oe <= !rr_s;
            remote_update_mode <= remote_en_r && (ap != 2'h0);
        end
    end

    // Start request: leaving reset or software restart, set wins
    // Idle spends a request, started or not, so no stale start later
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            pend_r <= 1'b0;
        end else begin
            pend_r <= (pend_r && st_r == ST_DATA) ||
                      (in_rst_d_r && !in_rst) || restart;
        end
    end

    // Parallel flash sequencer, device as master
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            st_r <= ST_IDLE;
            ph_r <= 3'h0;
            flash_word_address_bus <= 24'h00_0000;
            cfg_word <= 16'h0000;
            cfg_word_valid <= 1'b0;
        end else begin
            cfg_word_valid <= 1'b0;
            if (in_rst) begin
                st_r <= ST_IDLE;
                ph_r <= 3'h0;
            end else begin
                unique case (st_r)
                    ST_IDLE: begin
                        if (pend_r && ap != 2'h0) begin
                            st_r <= ST_ADDR;
                            ph_r <= 3'h0;
                            flash_word_address_bus <= 24'h00_0000;
                        end
                    end
                    ST_ADDR: begin
                        ph_r <= ph_r + 3'h1;
                        if (ph_r == `CFGL_ADDR_CYC - 3'h1) begin
                            st_r <= ST_DATA;
                            ph_r <= 3'h0;
                        end
                    end
                    ST_DATA: begin
                        ph_r <= ph_r + 3'h1;
                        if (ph_r == `CFGL_DATA_CYC - 3'h1) begin
                            cfg_word <= data_s;
                            cfg_word_valid <= 1'b1;
                            ph_r <= 3'h0;
                            flash_word_address_bus <=
                                flash_word_address_bus + 24'h00_0001;
                            st_r <= (flash_word_address_bus ==
                                     words_r - 24'h00_0001) ?
                                    ST_DONE : ST_ADDR;
                        end
                    end
                    ST_DONE: begin
                        if (pend_r && ap != 2'h0) begin
                            st_r <= ST_ADDR;
                            ph_r <= 3'h0;
                            flash_word_address_bus <= 24'h00_0000;
                        end
                    end
                endcase
            end
        end
    end

    // Flash control pins; loader reads only, so the data bus stays off
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            loader_clock_out <= 1'b0;
            flash_reset_low <= 1'b0;
            flash_ce_low <= 1'b1;
            flash_oe_low <= 1'b1;
            flash_avd_low <= 1'b1;
            flash_we_low <= 1'b1;
            flash_data_o <= 16'h0000;
            flash_data_oe <= 1'b0;
        end else begin
            loader_clock_out <= (st_r == ST_ADDR || st_r == ST_DATA) &&
                                !in_rst && !loader_clock_out;
            flash_reset_low <= !in_rst;
            flash_ce_low <= !((st_r == ST_ADDR || st_r == ST_DATA) &&
                              !in_rst);
            flash_avd_low <= !(st_r == ST_ADDR && !in_rst);
            flash_oe_low <= !(st_r == ST_DATA && !in_rst);
            flash_we_low <= 1'b1;
            flash_data_o <= 16'h0000;
            flash_data_oe <= 1'b0;
        end
    end

    // Bridge serialiser, MSB first, two aclk per serial bit
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            bit_cnt_r <= 4'h0;
            sh_r <= 8'h00;
            jtag_byte_ready <= 1'b0;
            as_clk_o <= 1'b0;
            as_cs_low_o <= 1'b1;
            as_data_o <= 1'b0;
            as_oe <= 1'b0;
        end else begin
            as_oe <= bridge_act;
            jtag_byte_ready <= bridge_act && bit_cnt_r == 4'h0 &&
                               !(jtag_byte_valid && jtag_byte_ready);
            if (!bridge_act) begin
                bit_cnt_r <= 4'h0;
                as_clk_o <= 1'b0;
                as_cs_low_o <= 1'b1;
            end else if (bit_cnt_r == 4'h0) begin
                as_clk_o <= 1'b0;
                if (jtag_byte_valid && jtag_byte_ready) begin
                    sh_r <= jtag_byte;
                    bit_cnt_r <= 4'h8;
                    as_cs_low_o <= 1'b0;
                end
            end else if (!as_clk_o) begin
                as_data_o <= sh_r[7];
                as_clk_o <= 1'b1;
                sh_r <= {sh_r[6:0], 1'b0};
            end else begin
                as_clk_o <= 1'b0;
                bit_cnt_r <= bit_cnt_r - 4'h1;
            end
        end
    end

    // AXI write channel; address and data taken in either order
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_hold_r <= 1'b0;
            w_hold_r <= 1'b0;
            awaddr_r <= 32'h0000_0000;
            wdata_r <= 32'h0000_0000;
            wstrb_r <= 4'h0;
            s_axi_awready <= 1'b0;
            s_axi_wready <= 1'b0;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= `CFGL_RESP_OKAY;
            remote_en_r <= 1'b0;
            bridge_en_r <= 1'b0;
            words_r <= `CFGL_WORDS_RST;
        end else begin
            s_axi_awready <= !aw_hold_r && !s_axi_awready;
            s_axi_wready <= !w_hold_r && !s_axi_wready;
            if (s_axi_awvalid && s_axi_awready) begin
                aw_hold_r <= 1'b1;
                awaddr_r <= s_axi_awaddr;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                w_hold_r <= 1'b1;
                wdata_r <= s_axi_wdata;
                wstrb_r <= s_axi_wstrb;
            end
            if (aw_hold_r && w_hold_r && !s_axi_bvalid) begin
                s_axi_bvalid <= 1'b1;
                s_axi_bresp <= `CFGL_RESP_OKAY;
                if (awaddr_r == `CFGL_OFF_CTRL && wstrb_r[0]) begin
                    remote_en_r <= wdata_r[`CFGL_CTRL_REMOTE];
                    bridge_en_r <= wdata_r[`CFGL_CTRL_BRIDGE];
                end else if (awaddr_r == `CFGL_OFF_WORDS) begin
                    for (int i = 0; i < 3; i++) begin
                        if (wstrb_r[i]) begin
                            words_r[8*i +: 8] <= wdata_r[8*i +: 8];
                        end
                    end
                end else if (awaddr_r != `CFGL_OFF_CTRL) begin
                    s_axi_bresp <= `CFGL_RESP_DECERR;
                end
            end
            if (s_axi_bvalid && s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
                aw_hold_r <= 1'b0;
                w_hold_r <= 1'b0;
            end
        end
    end

    // AXI read channel
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= 32'h0000_0000;
            s_axi_rresp <= `CFGL_RESP_OKAY;
        end else begin
            s_axi_arready <= !s_axi_rvalid && !s_axi_arready;
            if (s_axi_arvalid && s_axi_arready) begin
                s_axi_rvalid <= 1'b1;
                s_axi_rresp <= `CFGL_RESP_OKAY;
                s_axi_rdata <= 32'h0000_0000;
                unique case (s_axi_araddr)
                    `CFGL_OFF_CTRL: s_axi_rdata <=
                        {30'h0, bridge_en_r, remote_en_r};
                    `CFGL_OFF_STATUS: s_axi_rdata <=
                        {22'h0, chain_s, in_rst, st_r == ST_DONE,
                         st_r == ST_ADDR || st_r == ST_DATA,
                         ap_std_r, ap_fast_r, sel_s};
                    `CFGL_OFF_WORDS: s_axi_rdata <= {8'h00, words_r};
                    `CFGL_OFF_ADDR:
                        s_axi_rdata <= {8'h00, flash_word_address_bus};
                    default: s_axi_rresp <= `CFGL_RESP_DECERR;
                endcase
            end else if (s_axi_rvalid && s_axi_rready) begin
                s_axi_rvalid <= 1'b0;
            end
        end
    end

    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);

    chk_reset_idle: assert property (in_rst |=> st_r == ST_IDLE)
        else $error("sequencer left idle during reset");
    chk_status_pull: assert property (!rr_s |=> open_drain_status_low_oe)
        else $error("status not pulled low under reload request");
    chk_fast_codes: assert property (ap_fast_r |->
        ($past(sel_s) == 4'h5 || $past(sel_s) == 4'h6))
        else $error("fast flag on a wrong code");
    chk_std_codes: assert property (ap_std_r |-> ($past(sel_s) == 4'h7 ||
        $past(sel_s) == 4'h8 || $past(sel_s) == 4'hb))
        else $error("standard flag on a wrong code");
    chk_msb_absent: assert property (!HAS_SEL_MSB |->
        !(ap_fast_r || ap_std_r))
        else $error("parallel scheme without top select pin");
    chk_start_gate: assert property (st_r == ST_IDLE ##1
        st_r == ST_ADDR |-> $past(ap) != 2'h0)
        else $error("sequencer started on a non-parallel code");
    chk_word_capture: assert property (st_r == ST_DATA &&
        ph_r == `CFGL_DATA_CYC - 3'h1 &&
        !in_rst |=> cfg_word_valid && cfg_word == $past(data_s))
        else $error("flash word not handed over");
    chk_addr_step: assert property (cfg_word_valid |->
        flash_word_address_bus == $past(flash_word_address_bus) + 24'h1)
        else $error("word address did not step");
    chk_oe_gating: assert property (!flash_oe_low |->
        !flash_data_oe && $past(st_r) == ST_DATA)
        else $error("flash output enabled outside data phase");
    chk_master_clock: assert property (st_r == ST_DATA && !in_rst ##1
        st_r == ST_DATA && !in_rst |=> loader_clock_out !=
        $past(loader_clock_out))
        else $error("loader clock stalled while fetching");
    chk_remote_mode: assert property (remote_update_mode |->
        $past(remote_en_r) && $past(ap) != 2'h0)
        else $error("remote mode outside a parallel scheme");
    chk_bridge_yield: assert property (as_oe |-> !$past(chain_s))
        else $error("serial pins driven while chain disabled");
    chk_bridge_byte: assert property (as_oe && bit_cnt_r == 4'h0 &&
        jtag_byte_valid && jtag_byte_ready ##1 as_oe[*2] |->
        as_data_o == $past(jtag_byte[7], 2))
        else $error("bridge first bit differs from byte");
endmodule : cfgl_top

/* File: sim/cfgl_flash_model.sv */
/*
 Flash partner: parallel words and serial byte capture.
 Assumes the bench feeds it the loader's flash outputs.
*/
`timescale 1ns/1ps

module cfgl_flash_model (
    // Parallel flash
    input  wire logic        loader_clock_out,
    input  wire logic [23:0] flash_word_address_bus,
    input  wire logic        flash_ce_low,
    input  wire logic        flash_oe_low,
    output logic      [15:0] flash_data,
    // Serial flash
    input  wire logic        as_clk_o,
    input  wire logic        as_cs_low_o,
    input  wire logic        as_data_o,
    output logic      [7:0]  rx_byte,
    output int               rx_bits
);
    initial begin
        rx_byte = 8'h00;
        rx_bits = 0;
    end
    // Word steady before each clock rise; no pull, so idle bus inverts
    always_comb begin
        if (!flash_ce_low && !flash_oe_low) begin
            flash_data = flash_word_address_bus[15:0] ^ 16'h5a5a;
        end else begin
            flash_data = ~(flash_word_address_bus[15:0] ^ 16'h5a5a);
        end
    end
    // Bit held through the low half, so sample there
    always @(negedge as_clk_o) begin
        if (!as_cs_low_o) begin
            rx_byte <= {rx_byte[6:0], as_data_o};
            rx_bits <= rx_bits + 1;
        end
    end
endmodule : cfgl_flash_model

/* File: sim/testbench.sv */
/*
 Bench: registers, decode, fetch, reset hold, serial bridge.
 Assumes the package, design and flash model compile first.
*/
`timescale 1ns/1ps
`include "cfgl_consts.svh"

module testbench;
    logic        aclk, aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready;
    logic        s_axi_arvalid, s_axi_rready, s_axi_awready, s_axi_wready;
    logic        s_axi_bvalid, s_axi_arready, s_axi_rvalid, as_oe;
    logic [31:0] s_axi_awaddr, s_axi_wdata, s_axi_araddr, s_axi_rdata;
    logic [3:0]  s_axi_wstrb, scheme_select_pins;
    logic [1:0]  s_axi_bresp, s_axi_rresp, rs;
    logic        reload_request_low, chain_enable_low, ext_status_low;
    logic        open_drain_status_low_i, open_drain_status_low_o;
    logic        open_drain_status_low_oe, remote_update_mode;
    logic        loader_clock_out, flash_data_oe, flash_reset_low;
    logic        flash_ce_low, flash_oe_low, flash_avd_low, flash_we_low;
    logic [23:0] flash_word_address_bus;
    logic [15:0] flash_data_i, flash_data_o, cfg_word;
    logic        cfg_word_valid, jtag_byte_valid, jtag_byte_ready;
    logic [7:0]  jtag_byte, rx_byte;
    logic        as_clk_o, as_cs_low_o, as_data_o;
    int          rx_bits, clk_rises = 0, mismatches = 0, samples_checked = 0;
    logic [15:0] got[$];

    // Open-drain status wire with pull-up
    assign open_drain_status_low_i = ext_status_low &
        !(open_drain_status_low_oe && !open_drain_status_low_o);

    cfgl_top cfgl_top_inst (
        .aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
        .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready,
        .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
        .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
        .s_axi_rvalid, .s_axi_rready, .scheme_select_pins,
        .reload_request_low, .chain_enable_low, .open_drain_status_low_i,
        .open_drain_status_low_o, .open_drain_status_low_oe,
        .remote_update_mode, .loader_clock_out, .flash_word_address_bus,
        .flash_data_i, .flash_data_o, .flash_data_oe, .flash_reset_low,
        .flash_ce_low, .flash_oe_low, .flash_avd_low, .flash_we_low,
        .cfg_word, .cfg_word_valid, .jtag_byte, .jtag_byte_valid,
        .jtag_byte_ready, .as_clk_o, .as_cs_low_o, .as_data_o, .as_oe
    );

    cfgl_flash_model cfgl_flash_model_inst (
        .loader_clock_out, .flash_word_address_bus, .flash_ce_low,
        .flash_oe_low, .flash_data(flash_data_i), .as_clk_o, .as_cs_low_o,
        .as_data_o, .rx_byte, .rx_bits
    );

    initial begin
        aclk = 1'b0;
        forever #50 aclk = ~aclk;
    end

    always @(posedge aclk)
        if (cfg_word_valid === 1'b1) got.push_back(cfg_word);
    always @(posedge loader_clock_out) clk_rises++;
    always @(posedge aclk) begin
        if (aresetn && flash_we_low !== 1'b1) chk(1'b0, "flash written");
    end

    task automatic chk(input bit ok, input string m);
        samples_checked++;
        if (!ok) begin
            mismatches++;
            $display("MISMATCH t=%0t %s", $time, m);
        end
    endtask : chk

    task automatic wr(input logic [31:0] a, d);
        bit ad = 0, wd = 0;
        @(posedge aclk);
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        do begin
            @(posedge aclk);
            if (s_axi_awready && !ad) s_axi_awvalid <= 1'b0;
            if (s_axi_wready && !wd) s_axi_wvalid <= 1'b0;
            ad |= s_axi_awready;
            wd |= s_axi_wready;
        end while (!(s_axi_bvalid && ad && wd));
        s_axi_bready <= 1'b0;
        rs = s_axi_bresp;
    endtask : wr

    task automatic rd(input logic [31:0] a, output logic [31:0] d);
        @(posedge aclk);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        do @(posedge aclk); while (!s_axi_arready);
        s_axi_arvalid <= 1'b0;
        do @(posedge aclk); while (!s_axi_rvalid);
        s_axi_rready <= 1'b0;
        d = s_axi_rdata;
        rs = s_axi_rresp;
    endtask : rd

    task automatic t_regs();
        logic [31:0] d;
        rd(`CFGL_OFF_WORDS, d);
        chk(d[23:0] === `CFGL_WORDS_RST, "word count reset");
        rd(32'h0000_0040, d);
        chk(rs === `CFGL_RESP_DECERR && d === 32'h0, "unmapped read");
        wr(32'h0000_0040, 32'h1);
        chk(rs === `CFGL_RESP_DECERR, "unmapped write");
        $display("test regs done");
    endtask : t_regs

    // Reload still held low, so nothing may start while codes sweep
    task automatic t_decode();
        logic [31:0] d;
        logic [1:0]  e;
        for (int c = 0; c < 16; c++) begin
            scheme_select_pins <= 4'(c);
            repeat (8) @(posedge aclk);
            rd(`CFGL_OFF_STATUS, d);
            e = {c == 7 || c == 8 || c == 11, c == 5 || c == 6};
            chk({d[5:4], d[3:0]} === {e, 4'(c)}, "decode");
            chk(d[8] === 1'b1 && flash_reset_low === 1'b0,
                "held");
        end
        $display("test decode done");
    endtask : t_decode

    task automatic t_nonpar();
        logic [31:0] d;
        scheme_select_pins <= 4'h3;
        wr(`CFGL_OFF_CTRL, 32'h1);
        reload_request_low <= 1'b1;
        repeat (30) @(posedge aclk);
        rd(`CFGL_OFF_STATUS, d);
        chk(d[7:6] === 2'h0 && got.size() == 0, "no start");
        chk(remote_update_mode === 1'b0, "remote off");
        $display("test nonparallel done");
    endtask : t_nonpar

    task automatic t_load(input logic [3:0] code);
        logic [31:0] d = 0;
        int r0 = clk_rises;
        scheme_select_pins <= code;
        got.delete();
        wr(`CFGL_OFF_WORDS, 32'h3);
        wr(`CFGL_OFF_CTRL, 32'h5);
        for (int i = 0; i < 40 && !d[`CFGL_ST_DONE]; i++)
            rd(`CFGL_OFF_STATUS, d);
        chk(remote_update_mode === 1'b1, "remote on");
        chk(got.size() == 3, "word count");
        for (int k = 0; k < got.size(); k++)
            chk(got[k] === (16'(k) ^ 16'h5a5a), "word order");
        chk(clk_rises > r0 && flash_data_oe === 1'b0,
            "mastering");
        $display("test load done");
    endtask : t_load

    task automatic t_hold();
        logic [31:0] d;
        wr(`CFGL_OFF_CTRL, 32'h4);
        repeat (6) @(posedge aclk);
        ext_status_low <= 1'b0;
        repeat (8) @(posedge aclk);
        rd(`CFGL_OFF_STATUS, d);
        chk(d[8] === 1'b1 && d[6] === 1'b0 && flash_ce_low === 1'b1,
            "status hold");
        ext_status_low <= 1'b1;
        reload_request_low <= 1'b0;
        repeat (8) @(posedge aclk);
        chk(flash_reset_low === 1'b0 && open_drain_status_low_oe === 1'b1,
            "reload hold");
        reload_request_low <= 1'b1;
        repeat (60) @(posedge aclk);
        $display("test hold done");
    endtask : t_hold

    task automatic t_bridge();
        logic [31:0] d;
        int b0 = rx_bits;
        wr(`CFGL_OFF_CTRL, 32'h2);
        @(posedge aclk);
        jtag_byte <= 8'ha6;
        jtag_byte_valid <= 1'b1;
        do @(posedge aclk); while (!jtag_byte_ready);
        jtag_byte_valid <= 1'b0;
        repeat (24) @(posedge aclk);
        chk(rx_bits - b0 == 8 && rx_byte === 8'ha6, "bridged byte");
        chain_enable_low <= 1'b1;
        repeat (8) @(posedge aclk);
        rd(`CFGL_OFF_STATUS, d);
        chk(d[9] === 1'b1 && as_oe === 1'b0, "yield");
        chain_enable_low <= 1'b0;
        repeat (8) @(posedge aclk);
        chk(as_oe === 1'b1, "bridge back");
        $display("test bridge done");
    endtask : t_bridge

    task automatic report_and_stop();
        $display("checks %0d mismatches %0d", samples_checked, mismatches);
        if (mismatches == 0 && samples_checked > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask : report_and_stop

    initial begin
        #(6000 * 100);
        mismatches++;
        report_and_stop();
    end

    // Programmer holds reload low from power-up
    initial begin
        {aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready} = 4'h0;
        {s_axi_arvalid, s_axi_rready, jtag_byte_valid} = 3'h0;
        {s_axi_awaddr, s_axi_wdata, s_axi_araddr} = '0;
        s_axi_wstrb = 4'hf;
        scheme_select_pins = 4'h0;
        {reload_request_low, chain_enable_low, ext_status_low} = 3'h1;
        jtag_byte = 8'h00;
        repeat (2) @(posedge aclk);
        aresetn <= 1'b1;
        t_regs();
        t_decode();
        t_nonpar();
        t_load(4'h5);
        t_load(4'hb);
        t_hold();
        t_bridge();
        report_and_stop();
    end
endmodule : testbench
